// ### rtl/mcs_defs.vh
// Contract
// (R1) Pulse bit 0 resets whole board, reloads
// (R2) Pulse bits 1-5 reset sub-units
// (R3) Pulse bit 8 resets summing clock loops
// (R4) Pulse bit 9 clears parity and overflow
// (R5) Bits 10/11 reload crate/system FPGA
// (R6) Pulse bit 12 zeroes rate counters
// (R7) Pulse register reads zero; zeros ignored
// (R8) Status bit 0 sticky combined parity
// (R9) Status bits 1,4,5,6 configuration done
// (R10) Status bit 2 sticky FIFO overflow
// (R11) Status bits 7-11 ready and locks
// (R12) FIFO empties bits 0-3, fulls 4-7
// (R13) Per-slot sticky backplane parity flags
// (R14) Cable bits 0-2, crate bit 3 sticky
// (R15) Disabled slot feeds zero, odd parity
// (R16) Disabled cable link data forced zero
// (R17) Counter adds one per error cycle, saturates
// (R18) Counter starts zero; disabled links ignored
// (R19) Two slot phase registers, eight fields
// (R20) Cable phase register, three fields
// (R21) Four-bit pipeline latency setting
// (R22) Three-bit readout slice count
// (R23) Write address zero loads read offset
// (R24) Each pulse bit gives one-cycle request
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH
// Byte addresses on the A24/D16 register bus
`define MCS_ADDR_MODE 24'h000004
`define MCS_ADDR_PULSE 24'h000006
`define MCS_ADDR_STATUS 24'h000008
`define MCS_ADDR_FIFO 24'h00000A
`define MCS_ADDR_BPERRF 24'h00000C
`define MCS_ADDR_CBERRF 24'h00000E
`define MCS_ADDR_BPMASK 24'h000010
`define MCS_ADDR_CBMASK 24'h000012
`define MCS_ADDR_PCOUNT 24'h000014
`define MCS_ADDR_BPPH_LO 24'h000016
`define MCS_ADDR_BPPH_HI 24'h000018
`define MCS_ADDR_CBPH 24'h00001A
`define MCS_ADDR_PIPE 24'h00001C
`define MCS_ADDR_SLICE 24'h00001E
`define MCS_ADDR_OFS_BP 24'h000020
`define MCS_ADDR_OFS_CR 24'h000022
// Pulse bit positions
`define MCS_P_BOARD 0
`define MCS_P_TIMING 1
`define MCS_P_REGION 2
`define MCS_P_EVENT 3
`define MCS_P_FIELDBUS 4
`define MCS_P_TWOWIRE 5
`define MCS_P_DLL 8
`define MCS_P_CLEAR 9
`define MCS_P_RLD_CRATE 10
`define MCS_P_RLD_SYS 11
`define MCS_P_RATE 12
// Status bit positions
`define MCS_S_PARITY 0
`define MCS_S_LOADED 1
`define MCS_S_OVF 2
`define MCS_S_TWOWIRE_CFG 4
`define MCS_S_CRATE_CFG 5
`define MCS_S_SYS_CFG 6
`define MCS_S_TIMING_OK 7
`define MCS_S_CRATE_LCK 8
`define MCS_S_SYS_LCK 9
`define MCS_S_EVENT_OK 10
`define MCS_S_REGION_OK 11
`define MCS_S_OVF_REC 12
// Field widths and reset values
`define MCS_NSLOT 16
`define MCS_NCABLE 3
`define MCS_PIPE_W 4
`define MCS_SLICE_W 3
`define MCS_OFS_W 8
`define MCS_RST_REG 16'h0000
`define MCS_RST_SLICE 3'h1
`define MCS_COUNT_MAX 16'hFFFF
`endif

// ### rtl/mcs_offset_loader.v
`timescale 1ns/1ps
`include "mcs_defs.vh"
// Dual-port RAM address pair: read pointer runs the offset minus one ahead of write
module mcs_offset_loader (
	input wire clk,
	input wire resetn,
	input wire [`MCS_OFS_W-1:0] offset,
	output reg [`MCS_OFS_W-1:0] write_addr,
	output reg [`MCS_OFS_W-1:0] read_addr
);
	// Reload read counter each time write counter wraps to zero
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			write_addr <= 8'h00;
			read_addr <= 8'h00;
		end else begin
			write_addr <= write_addr + 8'h01;
			if (write_addr == 8'h00)
				read_addr <= offset; // [R23]
			else
				read_addr <= read_addr + 8'h01;
		end
	end
endmodule

// ### rtl/mcs_regs.v
`timescale 1ns/1ps
`include "mcs_defs.vh"
// Control and status register bank on the reduced A24/D16 bus
module mcs_regs (
	input wire clk,
	input wire resetn,
	input wire [23:0] bus_addr,
	input wire [15:0] bus_wdata,
	input wire bus_write,
	input wire bus_read,
	output reg [15:0] bus_rdata,
	output reg bus_ack,
	input wire [3:0] geo_address,
	input wire [`MCS_NSLOT-1:0] slot_parity_err,
	input wire [`MCS_NCABLE-1:0] cable_parity_err,
	input wire crate_data_parity_err,
	input wire [`MCS_NSLOT*8-1:0] slot_data_in,
	input wire [`MCS_NCABLE*8-1:0] cable_data_in,
	input wire fifo_overflow_event,
	input wire twowire_fpga_configured,
	input wire crate_fpga_configured,
	input wire system_fpga_configured,
	input wire timing_receiver_ok,
	input wire crate_clock_locked,
	input wire system_clock_locked,
	input wire event_link_ok,
	input wire region_link_ok,
	input wire crate_event_fifo_empty,
	input wire system_event_fifo_empty,
	input wire crate_region_fifo_empty,
	input wire system_region_fifo_empty,
	input wire crate_event_fifo_full,
	input wire system_event_fifo_full,
	input wire crate_region_fifo_full,
	input wire system_region_fifo_full,
	output reg board_reinit,
	output reg timing_receiver_reinit,
	output reg region_link_reinit,
	output reg event_link_reinit,
	output reg fieldbus_mcu_reinit,
	output reg twowire_reinit,
	output reg clock_loop_reinit,
	output reg error_flag_clear,
	output reg crate_fpga_reload,
	output reg system_fpga_reload,
	output reg rate_counter_clear,
	output reg [3:0] reload_geo_address,
	output reg [`MCS_NSLOT*9-1:0] slot_data_out,
	output reg [`MCS_NCABLE*8-1:0] cable_data_out,
	output reg [31:0] slot_phase_select,
	output reg [5:0] subsum_phase_select,
	output reg [`MCS_PIPE_W-1:0] pipeline_latency,
	output reg [`MCS_SLICE_W-1:0] readout_slices,
	output reg [`MCS_OFS_W-1:0] bp_read_addr,
	output reg [`MCS_OFS_W-1:0] cr_read_addr
);
	// Settings, mode and sticky error state
	reg [15:0] control_mode;
	reg [15:0] slot_input_mask;
	reg [2:0] cable_input_mask;
	reg [15:0] slot_parity_flags;
	reg [3:0] cable_parity_bits;
	reg [15:0] parity_tally;
	reg overflow_flag;
	reg overflow_recorded;
	reg [7:0] offset_bp;
	reg [7:0] offset_cr;
	reg geo_capture_pending;
	reg [15:0] next_rdata;

	// Loader read pointers; write counters stay inside the loaders
	wire [7:0] bp_read_int;
	wire [7:0] cr_read_int;

	// Pulse decode and live error terms
	wire pulse_write;
	wire [15:0] pulse_bits;
	wire clear_now;
	wire [15:0] slot_err_live;
	wire [3:0] cable_err_live;
	wire any_err;
	wire wipe_errors;

	// Write to pulse register decoded once; zero bits mean nothing
	assign pulse_write = bus_write && (bus_addr == `MCS_ADDR_PULSE);
	assign pulse_bits = pulse_write ? bus_wdata : 16'h0000; // [R7]
	assign clear_now = pulse_bits[`MCS_P_CLEAR]; // [R4]

	// Board reset also wipes the error record, as at power-on
	assign wipe_errors = clear_now | pulse_bits[`MCS_P_BOARD]; // [R1] [R4]

	// Masked links never raise errors, so they are never counted
	assign slot_err_live = slot_parity_err & ~slot_input_mask; // [R18]
	assign cable_err_live = {crate_data_parity_err,
		cable_parity_err & ~cable_input_mask}; // [R18]
	assign any_err = (|slot_err_live) | (|cable_err_live);

	// One-cycle requests toward each target unit
	// Bits 6, 7 and 13-15 drive nothing
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			board_reinit <= 1'b0;
			timing_receiver_reinit <= 1'b0;
			region_link_reinit <= 1'b0;
			event_link_reinit <= 1'b0;
			fieldbus_mcu_reinit <= 1'b0;
			twowire_reinit <= 1'b0;
			clock_loop_reinit <= 1'b0;
			error_flag_clear <= 1'b0;
			crate_fpga_reload <= 1'b0;
			system_fpga_reload <= 1'b0;
			rate_counter_clear <= 1'b0;
		end else begin
			board_reinit <= pulse_bits[`MCS_P_BOARD]; // [R1] [R24]
			timing_receiver_reinit <= pulse_bits[`MCS_P_TIMING]; // [R2]
			region_link_reinit <= pulse_bits[`MCS_P_REGION]; // [R2]
			event_link_reinit <= pulse_bits[`MCS_P_EVENT]; // [R2]
			fieldbus_mcu_reinit <= pulse_bits[`MCS_P_FIELDBUS]; // [R2]
			twowire_reinit <= pulse_bits[`MCS_P_TWOWIRE]; // [R2]
			clock_loop_reinit <= pulse_bits[`MCS_P_DLL]; // [R3]
			error_flag_clear <= clear_now; // [R4]
			// Board reset reloads both devices from backplane address
			crate_fpga_reload <= pulse_bits[`MCS_P_RLD_CRATE] |
				pulse_bits[`MCS_P_BOARD]; // [R5] [R1]
			system_fpga_reload <= pulse_bits[`MCS_P_RLD_SYS] |
				pulse_bits[`MCS_P_BOARD]; // [R5] [R1]
			rate_counter_clear <= pulse_bits[`MCS_P_RATE]; // [R6]
		end
	end

	// Geo bypass field is taken from the pins after reset or board reset
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			geo_capture_pending <= 1'b1;
			control_mode <= `MCS_RST_REG;
			reload_geo_address <= 4'h0;
		end else begin
			// Capture waits one edge so the pins win over a racing write
			geo_capture_pending <= pulse_bits[`MCS_P_BOARD]; // [R1]
			if (geo_capture_pending) begin
				control_mode <= {11'h000, geo_address, 1'b0}; // [R1]
			end else if (bus_write && bus_addr == `MCS_ADDR_MODE) begin
				control_mode <= {6'h00, bus_wdata[9:0]};
			end
			// Reload uses the bypass field; board reset uses pins
			if (pulse_bits[`MCS_P_BOARD])
				reload_geo_address <= geo_address; // [R1]
			else if (pulse_bits[`MCS_P_RLD_CRATE] | pulse_bits[`MCS_P_RLD_SYS])
				reload_geo_address <= control_mode[4:1]; // [R5]
		end
	end

	// Software-written settings; board reset returns them to power-on
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_input_mask <= `MCS_RST_REG;
			cable_input_mask <= 3'h0;
			slot_phase_select <= 32'h00000000;
			subsum_phase_select <= 6'h00;
			pipeline_latency <= 4'h0;
			readout_slices <= `MCS_RST_SLICE;
			offset_bp <= 8'h00;
			offset_cr <= 8'h00;
		end else if (pulse_bits[`MCS_P_BOARD]) begin
			// Same values as power-on; error flags follow wipe_errors
			slot_input_mask <= `MCS_RST_REG; // [R1]
			cable_input_mask <= 3'h0;
			slot_phase_select <= 32'h00000000;
			subsum_phase_select <= 6'h00;
			pipeline_latency <= 4'h0;
			readout_slices <= `MCS_RST_SLICE;
			offset_bp <= 8'h00;
			offset_cr <= 8'h00;
		end else if (bus_write) begin
			// Exact byte match; unmapped writes are acknowledged and lost
			if (bus_addr == `MCS_ADDR_BPMASK)
				slot_input_mask <= bus_wdata;
			else if (bus_addr == `MCS_ADDR_CBMASK)
				cable_input_mask <= bus_wdata[2:0];
			else if (bus_addr == `MCS_ADDR_BPPH_LO)
				slot_phase_select[15:0] <= bus_wdata; // [R19]
			else if (bus_addr == `MCS_ADDR_BPPH_HI)
				slot_phase_select[31:16] <= bus_wdata; // [R19]
			else if (bus_addr == `MCS_ADDR_CBPH)
				subsum_phase_select <= bus_wdata[5:0]; // [R20]
			else if (bus_addr == `MCS_ADDR_PIPE)
				pipeline_latency <= bus_wdata[3:0]; // [R21]
			else if (bus_addr == `MCS_ADDR_SLICE)
				readout_slices <= bus_wdata[2:0]; // [R22]
			else if (bus_addr == `MCS_ADDR_OFS_BP)
				offset_bp <= bus_wdata[7:0];
			else if (bus_addr == `MCS_ADDR_OFS_CR)
				offset_cr <= bus_wdata[7:0];
		end
	end

	// Sticky error flags; a new error in the clear cycle survives
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_parity_flags <= 16'h0000;
			cable_parity_bits <= 4'h0;
			overflow_flag <= 1'b0;
			overflow_recorded <= 1'b0;
		end else begin
			slot_parity_flags <= (wipe_errors ? 16'h0000 : slot_parity_flags)
				| slot_err_live; // [R13] [R4]
			cable_parity_bits <= (wipe_errors ? 4'h0 : cable_parity_bits)
				| cable_err_live; // [R14] [R4]
			// Overflow pair shares one set and one clear
			overflow_flag <= (overflow_flag & ~wipe_errors)
				| fifo_overflow_event; // [R10]
			overflow_recorded <= (overflow_recorded & ~wipe_errors)
				| fifo_overflow_event; // [R4]
		end
	end

	// Saturating error counter; one per cycle with any live error
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			parity_tally <= 16'h0000; // [R18]
		end else if (wipe_errors) begin
			// Clear with a live error leaves one, so no error is lost
			parity_tally <= any_err ? 16'h0001 : 16'h0000; // [R4]
		end else if (any_err && parity_tally != `MCS_COUNT_MAX) begin
			parity_tally <= parity_tally + 16'h0001; // [R17]
		end
	end

	// Link data gating; disabled slot gets zero data with odd parity bit
	genvar gi;
	generate
		for (gi = 0; gi < `MCS_NSLOT; gi = gi + 1) begin : g_slot
			always @(posedge clk or negedge resetn) begin
				if (!resetn)
					slot_data_out[gi*9 +: 9] <= 9'h100;
				else if (slot_input_mask[gi])
					slot_data_out[gi*9 +: 9] <= 9'h100; // [R15]
				else
					slot_data_out[gi*9 +: 9] <= {~^slot_data_in[gi*8 +: 8],
						slot_data_in[gi*8 +: 8]};
			end
		end
		// Cable links carry no parity bit of their own
		for (gi = 0; gi < `MCS_NCABLE; gi = gi + 1) begin : g_cable
			always @(posedge clk or negedge resetn) begin
				if (!resetn)
					cable_data_out[gi*8 +: 8] <= 8'h00;
				else if (cable_input_mask[gi])
					cable_data_out[gi*8 +: 8] <= 8'h00; // [R16]
				else
					cable_data_out[gi*8 +: 8] <= cable_data_in[gi*8 +: 8];
			end
		end
	endgenerate

	// Readout RAM address pairs for the two offset registers
	mcs_offset_loader u_bp_loader (
		.clk(clk),
		.resetn(resetn),
		.offset(offset_bp),
		.write_addr(),
		.read_addr(bp_read_int)
	);
	mcs_offset_loader u_cr_loader (
		.clk(clk),
		.resetn(resetn),
		.offset(offset_cr),
		.write_addr(),
		.read_addr(cr_read_int)
	);

	// Registered copies so every output leaves a flip-flop
	// Costs one cycle of lag against the loaders
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bp_read_addr <= 8'h00;
			cr_read_addr <= 8'h00;
		end else begin
			bp_read_addr <= bp_read_int; // [R23]
			cr_read_addr <= cr_read_int; // [R23]
		end
	end

	// Read mux; unmapped and pulse addresses read zero
	always @* begin
		next_rdata = 16'h0000;
		if (bus_addr == `MCS_ADDR_MODE)
			next_rdata = control_mode;
		else if (bus_addr == `MCS_ADDR_PULSE)
			next_rdata = 16'h0000; // [R7]
		// Status word, bit 15 down to bit 0
		else if (bus_addr == `MCS_ADDR_STATUS)
			next_rdata = {3'h0, overflow_recorded,
				region_link_ok, event_link_ok, system_clock_locked,
				crate_clock_locked, timing_receiver_ok, // [R11]
				system_fpga_configured, crate_fpga_configured,
				twowire_fpga_configured, 1'b0, // [R9]
				overflow_flag, // [R10]
				twowire_fpga_configured & crate_fpga_configured
					& system_fpga_configured, // [R9]
				(|slot_parity_flags) | (|cable_parity_bits)}; // [R8]
		// Empties in the low nibble, fulls above
		else if (bus_addr == `MCS_ADDR_FIFO)
			next_rdata = {8'h00, system_region_fifo_full, crate_region_fifo_full,
				system_event_fifo_full, crate_event_fifo_full,
				system_region_fifo_empty, crate_region_fifo_empty,
				system_event_fifo_empty, crate_event_fifo_empty}; // [R12]
		else if (bus_addr == `MCS_ADDR_BPERRF)
			next_rdata = slot_parity_flags; // [R13]
		else if (bus_addr == `MCS_ADDR_CBERRF)
			next_rdata = {12'h000, cable_parity_bits}; // [R14]
		else if (bus_addr == `MCS_ADDR_BPMASK)
			next_rdata = slot_input_mask;
		else if (bus_addr == `MCS_ADDR_CBMASK)
			next_rdata = {13'h0000, cable_input_mask};
		else if (bus_addr == `MCS_ADDR_PCOUNT)
			next_rdata = parity_tally; // [R17]
		else if (bus_addr == `MCS_ADDR_BPPH_LO)
			next_rdata = slot_phase_select[15:0];
		else if (bus_addr == `MCS_ADDR_BPPH_HI)
			next_rdata = slot_phase_select[31:16];
		else if (bus_addr == `MCS_ADDR_CBPH)
			next_rdata = {10'h000, subsum_phase_select};
		else if (bus_addr == `MCS_ADDR_PIPE)
			next_rdata = {12'h000, pipeline_latency};
		else if (bus_addr == `MCS_ADDR_SLICE)
			next_rdata = {13'h0000, readout_slices};
		else if (bus_addr == `MCS_ADDR_OFS_BP)
			next_rdata = {8'h00, offset_bp};
		else if (bus_addr == `MCS_ADDR_OFS_CR)
			next_rdata = {8'h00, offset_cr};
	end

	// Bus answer one cycle after the strobe, held only that cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_rdata <= 16'h0000;
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_read | bus_write;
			bus_rdata <= bus_read ? next_rdata : 16'h0000;
		end
	end
endmodule

// ### tb/mcs_regs_assertions.sv
`timescale 1ns/1ps
`include "mcs_defs.vh"
// Watches the bus and the pulse outputs of the register bank
module mcs_regs_sva (
	input wire clk,
	input wire resetn,
	input wire [23:0] bus_addr,
	input wire [15:0] bus_wdata,
	input wire bus_write,
	input wire bus_read,
	input wire [15:0] bus_rdata,
	input wire bus_ack,
	input wire board_reinit,
	input wire timing_receiver_reinit,
	input wire clock_loop_reinit,
	input wire error_flag_clear,
	input wire crate_fpga_reload,
	input wire system_fpga_reload,
	input wire rate_counter_clear,
	input wire [2:0] readout_slices
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Write strobe aimed at the pulse register
	wire pw = bus_write && bus_addr == `MCS_ADDR_PULSE;
	a_ack_one_cycle: assert property (bus_ack == $past(bus_write || bus_read))
		else $error("ack not one cycle after strobe");
	a_rdata_idle_zero: assert property (!bus_ack |-> bus_rdata == 16'h0000)
		else $error("read data outside ack");
	a_pulse_reads_zero: assert property (bus_read && bus_addr == `MCS_ADDR_PULSE |=>
		bus_rdata == 16'h0000) else $error("pulse register read not zero");
	a_board_reload_pair: assert property (board_reinit |-> crate_fpga_reload &&
		system_fpga_reload) else $error("board reset without reloads");
	a_timing_reinit: assert property (pw && bus_wdata[1] |=> timing_receiver_reinit)
		else $error("timing receiver reset missing");
	a_loop_reinit: assert property (pw && bus_wdata[8] |=> clock_loop_reinit)
		else $error("clock loop reset missing");
	a_clear_pulse: assert property (pw && bus_wdata[9] |=> error_flag_clear)
		else $error("error clear missing");
	a_rate_clear: assert property (pw && bus_wdata[12] |=> rate_counter_clear)
		else $error("rate clear missing");
	a_no_stray_pulse: assert property (!pw |=> !board_reinit && !error_flag_clear
		&& !rate_counter_clear && !clock_loop_reinit) else $error("pulse without write");
	a_slices_reset: assert property ($rose(resetn) |-> readout_slices == 3'h1)
		else $error("slice count reset value");
	c_board: cover property (board_reinit);
	c_clear: cover property (error_flag_clear);
	c_read: cover property (bus_read ##1 bus_ack);
endmodule
bind mcs_regs mcs_regs_sva i_mcs_regs_sva (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
	.bus_rdata(bus_rdata), .bus_ack(bus_ack), .board_reinit(board_reinit),
	.timing_receiver_reinit(timing_receiver_reinit), .clock_loop_reinit(clock_loop_reinit),
	.error_flag_clear(error_flag_clear), .crate_fpga_reload(crate_fpga_reload),
	.system_fpga_reload(system_fpga_reload), .rate_counter_clear(rate_counter_clear),
	.readout_slices(readout_slices));

// ### tb/mcs_regs_tb.sv
`timescale 1ns/1ps
`include "mcs_defs.vh"
module mcs_regs_tb;
	typedef struct packed {logic [23:0] a; logic w; logic [15:0] d; logic [7:0] st, ff;
		logic [15:0] e;} mcs_row_t;
	mcs_row_t rows[19];
	logic clk = 0, resetn = 0, bus_write = 0, bus_read = 0, crate_data_parity_err = 0;
	logic fifo_overflow_event = 0;
	logic [23:0] bus_addr = 0, cable_data_in = 0;
	logic [15:0] bus_wdata = 0, slot_parity_err = 0, v, pv_seen;
	logic [2:0] cable_parity_err = 0;
	logic [3:0] geo_address = 4'h9;
	logic [127:0] slot_data_in = 0;
	logic [7:0] st_in = 0, ff_in = 0, r1, q1, dd;
	logic [31:0] cyc = 0, c1;
	integer num_errors = 0, checks = 0, i;
	wire bus_ack, board_reinit, timing_receiver_reinit, region_link_reinit, event_link_reinit;
	wire fieldbus_mcu_reinit, twowire_reinit, clock_loop_reinit, error_flag_clear;
	wire crate_fpga_reload, system_fpga_reload, rate_counter_clear;
	wire [15:0] bus_rdata;
	wire [3:0] reload_geo_address, pipeline_latency;
	wire [143:0] slot_data_out;
	wire [23:0] cable_data_out;
	wire [31:0] slot_phase_select;
	wire [5:0] subsum_phase_select;
	wire [2:0] readout_slices;
	wire [7:0] bp_read_addr, cr_read_addr;
	// Pulse outputs gathered in pulse register bit order
	wire [15:0] pv = {3'b0, rate_counter_clear, system_fpga_reload, crate_fpga_reload,
		error_flag_clear, clock_loop_reinit, 2'b0, twowire_reinit, fieldbus_mcu_reinit,
		event_link_reinit, region_link_reinit, timing_receiver_reinit, board_reinit};
	mcs_regs i_mcs_regs (.clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.geo_address(geo_address), .slot_parity_err(slot_parity_err),
		.cable_parity_err(cable_parity_err), .crate_data_parity_err(crate_data_parity_err),
		.slot_data_in(slot_data_in), .cable_data_in(cable_data_in),
		.fifo_overflow_event(fifo_overflow_event), .twowire_fpga_configured(st_in[0]),
		.crate_fpga_configured(st_in[1]), .system_fpga_configured(st_in[2]),
		.timing_receiver_ok(st_in[3]), .crate_clock_locked(st_in[4]),
		.system_clock_locked(st_in[5]), .event_link_ok(st_in[6]), .region_link_ok(st_in[7]),
		.crate_event_fifo_empty(ff_in[0]), .system_event_fifo_empty(ff_in[1]),
		.crate_region_fifo_empty(ff_in[2]), .system_region_fifo_empty(ff_in[3]),
		.crate_event_fifo_full(ff_in[4]), .system_event_fifo_full(ff_in[5]),
		.crate_region_fifo_full(ff_in[6]), .system_region_fifo_full(ff_in[7]),
		.board_reinit(board_reinit), .timing_receiver_reinit(timing_receiver_reinit),
		.region_link_reinit(region_link_reinit), .event_link_reinit(event_link_reinit),
		.fieldbus_mcu_reinit(fieldbus_mcu_reinit), .twowire_reinit(twowire_reinit),
		.clock_loop_reinit(clock_loop_reinit), .error_flag_clear(error_flag_clear),
		.crate_fpga_reload(crate_fpga_reload), .system_fpga_reload(system_fpga_reload),
		.rate_counter_clear(rate_counter_clear), .reload_geo_address(reload_geo_address),
		.slot_data_out(slot_data_out), .cable_data_out(cable_data_out),
		.slot_phase_select(slot_phase_select), .subsum_phase_select(subsum_phase_select),
		.pipeline_latency(pipeline_latency), .readout_slices(readout_slices),
		.bp_read_addr(bp_read_addr), .cr_read_addr(cr_read_addr));
	// Clock and free cycle count
	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	task wrap_up;
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// tick, wr, rd and rc each leave one delay unit after a rising edge
	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input [23:0] a, input [15:0] d);
		bus_addr = a;
		bus_wdata = d;
		bus_write = 1;
		tick(1);
		bus_write = 0;
		pv_seen = pv;
		chk(bus_ack, 1);
		// Idle edge so the next access never re-raises a strobe at once
		tick(1);
	endtask
	task rd(input [23:0] a);
		bus_addr = a;
		bus_read = 1;
		tick(1);
		bus_read = 0;
		v = bus_rdata;
		chk(bus_ack, 1);
		tick(1);
	endtask
	task rc(input [23:0] a, input [15:0] e);
		rd(a);
		chk(v, e);
	endtask
	// Watchdog: a hang ends the run as a failure
	initial begin
		#9000000;
		num_errors++;
		$display("ERROR %0t: run did not finish in time", $time);
		wrap_up();
	end
	initial begin
		rows[0] = '{`MCS_ADDR_PCOUNT, 0, 0, 0, 0, 0};
		rows[1] = '{`MCS_ADDR_SLICE, 0, 0, 0, 0, 1};
		rows[2] = '{`MCS_ADDR_BPERRF, 0, 0, 0, 0, 0};
		rows[3] = '{`MCS_ADDR_STATUS, 0, 0, 8'hFF, 0, 16'h0FF2};
		rows[4] = '{`MCS_ADDR_STATUS, 0, 0, 8'h07, 0, 16'h0072};
		rows[5] = '{`MCS_ADDR_STATUS, 0, 0, 8'h03, 0, 16'h0030};
		rows[6] = '{`MCS_ADDR_FIFO, 0, 0, 0, 8'h5A, 16'h005A};
		rows[7] = '{`MCS_ADDR_FIFO, 0, 0, 0, 8'hA5, 16'h00A5};
		rows[8] = '{`MCS_ADDR_BPMASK, 1, 16'hFFFF, 0, 0, 16'hFFFF};
		rows[9] = '{`MCS_ADDR_CBMASK, 1, 16'h0005, 0, 0, 16'h0005};
		rows[10] = '{`MCS_ADDR_BPPH_LO, 1, 16'hC3A5, 0, 0, 16'hC3A5};
		rows[11] = '{`MCS_ADDR_BPPH_HI, 1, 16'h5A3C, 0, 0, 16'h5A3C};
		rows[12] = '{`MCS_ADDR_CBPH, 1, 16'h0027, 0, 0, 16'h0027};
		rows[13] = '{`MCS_ADDR_PIPE, 1, 16'h0009, 0, 0, 16'h0009};
		rows[14] = '{`MCS_ADDR_SLICE, 1, 16'h0005, 0, 0, 16'h0005};
		rows[15] = '{`MCS_ADDR_OFS_BP, 1, 16'h00A5, 0, 0, 16'h00A5};
		rows[16] = '{`MCS_ADDR_OFS_CR, 1, 16'h003C, 0, 0, 16'h003C};
		rows[17] = '{`MCS_ADDR_PULSE, 1, 16'h0000, 0, 0, 16'h0000};
		rows[18] = '{24'h000040, 1, 16'h1234, 0, 0, 16'h0000};
		repeat (3) @(posedge clk);
		#1 resetn = 1;
		tick(1);
		chk(readout_slices, 3'h1);
		// Register table: status levels, FIFO flags, settings read back
		for (i = 0; i < 19; i++) begin
			st_in = rows[i].st;
			ff_in = rows[i].ff;
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			tick(2);
			rc(rows[i].a, rows[i].e);
		end
		chk(slot_phase_select, 32'h5A3CC3A5);
		chk(subsum_phase_select, 6'h27);
		chk(pipeline_latency, 4'h9);
		chk(readout_slices, 3'h5);
		// Reload uses the bypass field, not the backplane address
		wr(`MCS_ADDR_MODE, 16'h0014);
		wr(`MCS_ADDR_PULSE, 16'h0400);
		tick(2);
		chk(reload_geo_address, 4'hA);
		// Each pulse bit alone; null bits give nothing
		for (i = 15; i >= 0; i--) begin
			wr(`MCS_ADDR_PULSE, 16'h0001 << i);
			chk(pv_seen, (i == 6 || i == 7 || i > 12) ? 0 : i == 0 ? 16'h0C01 : 1 << i);
		end
		tick(2);
		chk(reload_geo_address, geo_address);
		chk(pipeline_latency, 4'h0);
		rc(`MCS_ADDR_MODE, 16'h0012);
		// Sticky parity flags and counter, one error cycle each
		slot_parity_err = 16'h8001;
		tick(1);
		slot_parity_err = 0;
		cable_parity_err = 3'b100;
		tick(1);
		cable_parity_err = 0;
		crate_data_parity_err = 1;
		tick(1);
		crate_data_parity_err = 0;
		fifo_overflow_event = 1;
		tick(1);
		fifo_overflow_event = 0;
		tick(2);
		rc(`MCS_ADDR_BPERRF, 16'h8001);
		rc(`MCS_ADDR_CBERRF, 16'h000C);
		rc(`MCS_ADDR_PCOUNT, 16'h0003);
		rc(`MCS_ADDR_STATUS, 16'h1005);
		// Masked slot errors are not counted
		wr(`MCS_ADDR_BPMASK, 16'h0001);
		slot_parity_err = 16'h0001;
		tick(2);
		slot_parity_err = 0;
		tick(2);
		rc(`MCS_ADDR_PCOUNT, 16'h0003);
		wr(`MCS_ADDR_PULSE, 16'h0200);
		tick(1);
		rc(`MCS_ADDR_BPERRF, 16'h0000);
		rc(`MCS_ADDR_CBERRF, 16'h0000);
		rc(`MCS_ADDR_PCOUNT, 16'h0000);
		rc(`MCS_ADDR_STATUS, 16'h0000);
		// Long error run must stop at full scale
		slot_parity_err = 16'h0002;
		tick(65540);
		slot_parity_err = 0;
		tick(2);
		rc(`MCS_ADDR_PCOUNT, 16'hFFFF);
		// Masked inputs: slot 0 and cable 0
		wr(`MCS_ADDR_CBMASK, 16'h0001);
		slot_data_in[15:0] = 16'h03FF;
		cable_data_in = 24'h00427E;
		tick(3);
		chk(slot_data_out[8:0], 9'h100);
		chk(slot_data_out[17:9], 9'h103);
		chk(cable_data_out[15:0], 16'h4200);
		// Read pointer shifts by exactly the offset once the write counter wraps
		tick(300);
		c1 = cyc;
		r1 = bp_read_addr;
		q1 = cr_read_addr;
		wr(`MCS_ADDR_OFS_BP, 16'h00A5);
		wr(`MCS_ADDR_OFS_CR, 16'h003C);
		tick(600);
		dd = bp_read_addr - r1 - (cyc - c1);
		chk(dd, 8'hA5);
		dd = cr_read_addr - q1 - (cyc - c1);
		chk(dd, 8'h3C);
		// Board reset wipes the error record left by the long run
		wr(`MCS_ADDR_PULSE, 16'h0001);
		rc(`MCS_ADDR_PCOUNT, 16'h0000);
		rc(`MCS_ADDR_BPERRF, 16'h0000);
		// Mid-run reset after one fresh error; requests wait two edges
		slot_parity_err = 16'h0002;
		tick(1);
		slot_parity_err = 0;
		resetn = 0;
		tick(1);
		chk(cable_data_out, 24'h000000);
		resetn = 1;
		tick(2);
		rc(`MCS_ADDR_PCOUNT, 16'h0000);
		chk(cable_data_out, 24'h00427E);
		wrap_up();
	end
endmodule
